// File: rtl/scu_pkg.sv
// package for the serial channel uart block: register map, field layout, types
package scu_pkg;
   // register offsets (word index on the plain port)
   localparam logic [3:0] ADDR_TX_MODE   = 4'h0;
   localparam logic [3:0] ADDR_TX_COMM   = 4'h1;
   localparam logic [3:0] ADDR_TX_DATA   = 4'h2;
   localparam logic [3:0] ADDR_RX_MODE   = 4'h3;
   localparam logic [3:0] ADDR_RX_COMM   = 4'h4;
   localparam logic [3:0] ADDR_RX_DATA   = 4'h5;
   localparam logic [3:0] ADDR_CTRL      = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK  = 4'h8;
   // mode register fields
   localparam int MODE_OPCLK_BIT  = 15;
   localparam int MODE_XCLK_BIT   = 14;
   localparam int MODE_STRIG_BIT  = 8;
   localparam int MODE_RXINV_BIT  = 6;
   localparam int MODE_PROTO_LSB  = 1;
   localparam int MODE_IRQSRC_BIT = 0;
   // communication setting fields, plus the divider field of the data register
   localparam int COMM_TXE_BIT    = 15;
   localparam int COMM_RXE_BIT    = 14;
   localparam int COMM_EOC_BIT    = 10;
   localparam int COMM_PAR_LSB    = 8;
   localparam int COMM_ORDER_BIT  = 7;
   localparam int COMM_STOP_LSB   = 4;
   localparam int COMM_LEN_LSB    = 0;
   localparam int DATA_DIV_LSB    = 9;
   // control register: bit 0 starts the tx channel, bit 1 the rx channel
   localparam int CTRL_TX_START   = 0;
   localparam int CTRL_RX_START   = 1;
   // interrupt status bits
   localparam int IRQ_TX_BIT      = 0;
   localparam int IRQ_RX_BIT      = 1;
   localparam int IRQ_ERR_BIT     = 2;
   // reset values
   localparam logic [15:0] RST_MODE = 16'h0022;
   localparam logic [15:0] RST_COMM = 16'h0097;
   localparam logic [15:0] RST_DATA = 16'hce00;
   // receive enable settle time in system clocks
   localparam int RX_SETTLE_CYC   = 4;
   // protocol and option codes
   localparam logic [1:0] PROTO_UART = 2'h1;
   localparam logic [1:0] PAR_NONE   = 2'h0;
   localparam logic [1:0] PAR_ZERO   = 2'h1;
   localparam logic [1:0] PAR_EVEN   = 2'h2;
   localparam logic [1:0] PAR_ODD    = 2'h3;
   localparam logic [1:0] LEN_9      = 2'h1;
   localparam logic [1:0] LEN_7      = 2'h2;

   // per-channel setup as decoded from the registers
   typedef struct packed {
      logic       op_clock_select;
      logic       transfer_clock_source;
      logic [1:0] proto;
      logic       irq_source_select;
      logic       error_irq_enable;
      logic [1:0] parity_mode;
      logic       bit_order;
      logic [1:0] stop_len;
      logic [1:0] frame_len;
      logic [6:0] divider;
   } scu_cfg_t;

   typedef enum logic [1:0] {SCU_CH_TX, SCU_CH_RX} scu_dir_t;
endpackage

// File: rtl/scu_channel.sv
// one serial channel engine: baud divider plus transmit or receive shifter
`timescale 1ns/1ps
module scu_channel
   import scu_pkg::*;
#(
   parameter bit IS_RX = 1'b0
) (
   // clock and reset
   input  wire logic     i_mclk,
   input  wire logic     i_rstn,
   // setup
   input  wire scu_cfg_t i_cfg,
   input  wire logic     i_dir_en,
   input  wire logic     i_ck0_en,
   input  wire logic     i_ck1_en,
   input  wire logic     i_sck,
   input  wire logic     i_start,
   input  wire logic     i_edge_start_en,
   input  wire logic     i_rx_invert,
   input  wire logic [8:0] i_tx_data,
   // serial pins
   input  wire logic     i_rxd,
   output logic          o_txd,
   // status
   output logic          o_busy,
   output logic          o_buf_empty,
   output logic          o_done,
   output logic          o_err,
   output logic [8:0]    o_rx_data
);
   typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} scu_st_t;
   scu_st_t    state_r;
   logic [7:0] div_cnt_r;
   logic       sck_q_r;
   logic [3:0] bit_cnt_r;
   logic [1:0] stop_cnt_r;
   logic [8:0] shift_r;
   logic       par_r;
   logic       rxd_q_r;
   logic       op_tick;
   logic       bit_tick;
   logic [3:0] nbits;
   logic       rx_lvl;
   logic       start_edge;
   logic       tx_bit;

   assign op_tick = i_cfg.op_clock_select ? i_ck1_en : i_ck0_en;
   // frame length decode
   assign nbits = (i_cfg.frame_len == LEN_9) ? 4'h9 :
                  (i_cfg.frame_len == LEN_7) ? 4'h7 : 4'h8;
   assign rx_lvl = i_rxd ^ i_rx_invert;
   // next data bit to leave: msb first picks bit nbits-1, lsb first bit 0
   assign tx_bit = i_cfg.bit_order ? shift_r[0] : shift_r[nbits - 4'h1];
   // inverted level turns a rising pin edge into the start edge
   assign start_edge = rxd_q_r & ~rx_lvl;

   // transfer clock: internal divider by 2*(div+1), or sck rising edge
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_cnt_r <= 8'h00;
         sck_q_r   <= 1'b0;
         rxd_q_r   <= 1'b1;
      end else begin
         sck_q_r <= i_sck;
         rxd_q_r <= rx_lvl;
         if (state_r == ST_IDLE)
            div_cnt_r <= 8'h00;
         else if (op_tick)
            div_cnt_r <= bit_tick ? 8'h00 : div_cnt_r + 8'h01;
      end
   end
   assign bit_tick = i_cfg.transfer_clock_source ? (i_sck & ~sck_q_r) :
                     (op_tick && div_cnt_r == {i_cfg.divider, 1'b1});

   // frame sequencer
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         stop_cnt_r <= 2'h0;
         shift_r    <= 9'h000;
         par_r      <= 1'b0;
         o_done     <= 1'b0;
         o_err      <= 1'b0;
         o_rx_data  <= 9'h000;
         o_txd      <= 1'b1;
      end else begin
         o_done <= 1'b0;
         o_err  <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               o_txd <= 1'b1;
               // edge start only when the trigger bit allows it
               if (i_dir_en && (i_start || (IS_RX && i_edge_start_en && start_edge))) begin
                  state_r <= ST_START;
                  shift_r <= IS_RX ? 9'h000 : i_tx_data;
                  par_r   <= 1'b0;
                  if (!IS_RX)
                     o_txd <= 1'b0;
               end
            end
            ST_START: if (bit_tick) begin
               state_r   <= ST_DATA;
               bit_cnt_r <= 4'h0;
               // each cell is launched as the previous one ends, so no cell runs long
               if (!IS_RX) begin
                  o_txd   <= tx_bit;
                  par_r   <= tx_bit;
                  shift_r <= i_cfg.bit_order ? {1'b0, shift_r[8:1]} : {shift_r[7:0], 1'b0};
               end
            end
            ST_DATA: if (bit_tick) begin
               // rx enters msb first at bit 0, lsb first at bit nbits-1
               if (IS_RX) begin
                  if (i_cfg.bit_order)
                     shift_r <= {1'b0, shift_r[8:1]} | ({8'h00, rx_lvl} << (nbits - 4'h1));
                  else
                     shift_r <= {shift_r[7:0], rx_lvl};
                  par_r <= par_r ^ rx_lvl;
               end else if (bit_cnt_r == nbits - 4'h1) begin
                  // last data cell ends: parity cell or first stop cell follows
                  unique case (i_cfg.parity_mode)
                     PAR_NONE: o_txd <= 1'b1;
                     PAR_ZERO: o_txd <= 1'b0;
                     PAR_EVEN: o_txd <= par_r;
                     PAR_ODD:  o_txd <= ~par_r;
                  endcase
               end else begin
                  o_txd   <= tx_bit;
                  par_r   <= par_r ^ tx_bit;
                  shift_r <= i_cfg.bit_order ? {1'b0, shift_r[8:1]} : {shift_r[7:0], 1'b0};
               end
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (bit_cnt_r == nbits - 4'h1) begin
                  state_r    <= (i_cfg.parity_mode != PAR_NONE) ? ST_PAR : ST_STOP;
                  stop_cnt_r <= 2'h0;
               end
            end
            ST_PAR: if (bit_tick) begin
               state_r <= ST_STOP;
               if (IS_RX) begin
                  // zero mode takes the bit unchecked
                  if ((i_cfg.parity_mode == PAR_EVEN && (par_r ^ rx_lvl)) ||
                      (i_cfg.parity_mode == PAR_ODD && !(par_r ^ rx_lvl)))
                     o_err <= 1'b1;
               end else
                  o_txd <= 1'b1;                                    // first stop cell
            end
            ST_STOP: begin
               if (!IS_RX)
                  o_txd <= 1'b1;
               // zero stop bits ends at once; done after last stop bit shifts out
               if (i_cfg.stop_len == 2'h0 || (bit_tick && stop_cnt_r + 2'h1 >= i_cfg.stop_len)) begin
                  state_r <= ST_IDLE;
                  o_done  <= 1'b1;
                  if (IS_RX)
                     o_rx_data <= shift_r;
                  if (IS_RX && i_cfg.stop_len != 2'h0 && !rx_lvl)
                     o_err <= 1'b1;                                 // framing error
               end else if (bit_tick)
                  stop_cnt_r <= stop_cnt_r + 2'h1;
            end
         endcase
      end
   end

   assign o_busy      = (state_r != ST_IDLE);
   // shift register is free once data bits start moving
   assign o_buf_empty = (state_r == ST_IDLE) || (state_r == ST_START && bit_tick);
endmodule

// File: rtl/scu_top.sv
// serial channel pair set up as a uart: registers, prescaler, interrupts
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module scu_top
   import scu_pkg::*;
#(
   parameter int PRESC_W = 12
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   // prescaler ratios as powers of two (0..11)
   input  wire logic [3:0]  i_presc0_sel,
   input  wire logic [3:0]  i_presc1_sel,
   // serial pins
   input  wire logic        i_sck,
   input  wire logic        i_rxd,
   output logic             o_txd,
   // interrupt and uart mode flag
   output logic             o_irq,
   output logic             o_uart_mode
);
   logic [15:0] tx_channel_mode_r;
   logic [15:0] tx_channel_comm_setting_r;
   logic [15:0] tx_channel_data_divider_r;
   logic [15:0] rx_channel_mode_r;
   logic [15:0] rx_channel_comm_setting_r;
   logic [15:0] rx_channel_data_divider_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_stat_nxt;
   logic [2:0]  irq_mask_r;
   logic [PRESC_W-1:0] presc_r;
   logic        ck0_en;
   logic        ck1_en;
   logic        tx_start_r;
   logic        rx_start_r;
   logic [8:0]  tx_hold_r;
   scu_cfg_t    tx_cfg;
   scu_cfg_t    rx_cfg;
   logic        tx_busy;
   logic        tx_empty;
   logic        tx_done;
   logic        rx_done;
   logic        rx_err;
   logic        tx_err;
   logic [8:0]  rx_data;
   logic        tx_empty_q_r;
   logic        tx_evt;

   // common decode of a mode, setting and data register set
   function automatic scu_cfg_t decode_cfg(input logic [15:0] m, input logic [15:0] c,
                                           input logic [15:0] d);
      scu_cfg_t f;
      f.op_clock_select       = m[MODE_OPCLK_BIT];
      f.transfer_clock_source = m[MODE_XCLK_BIT];
      f.proto                 = m[MODE_PROTO_LSB +: 2];
      f.irq_source_select     = m[MODE_IRQSRC_BIT];
      f.error_irq_enable      = c[COMM_EOC_BIT];
      f.parity_mode           = c[COMM_PAR_LSB +: 2];
      f.bit_order             = c[COMM_ORDER_BIT];
      f.stop_len              = c[COMM_STOP_LSB +: 2];
      f.frame_len             = c[COMM_LEN_LSB +: 2];
      f.divider               = d[DATA_DIV_LSB +: 7];
      return f;
   endfunction

   assign tx_cfg = decode_cfg(tx_channel_mode_r, tx_channel_comm_setting_r,
                              tx_channel_data_divider_r);
   assign rx_cfg = decode_cfg(rx_channel_mode_r, rx_channel_comm_setting_r,
                              rx_channel_data_divider_r);

   // free running prescaler; each output is a one-cycle enable every 2^sel clocks
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn)
         presc_r <= '0;
      else
         presc_r <= presc_r + 1'b1;
   end
   function automatic logic presc_tick(input logic [PRESC_W-1:0] cnt, input logic [3:0] sel);
      logic [PRESC_W-1:0] m;
      m = (PRESC_W'(1) << sel) - PRESC_W'(1);
      return (cnt & m) == m;
   endfunction
   assign ck0_en = presc_tick(presc_r, i_presc0_sel);
   assign ck1_en = presc_tick(presc_r, i_presc1_sel);

   // register writes; illegal protocol code 11 is left to software
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_channel_mode_r         <= RST_MODE;
         tx_channel_comm_setting_r <= RST_COMM;
         tx_channel_data_divider_r <= RST_DATA;
         rx_channel_mode_r         <= RST_MODE;
         rx_channel_comm_setting_r <= RST_COMM;
         rx_channel_data_divider_r <= RST_DATA;
         irq_mask_r                <= 3'h0;
         tx_hold_r                 <= 9'h000;
      end else if (i_wr) begin
         unique case (i_addr)
            ADDR_TX_MODE:  tx_channel_mode_r         <= i_wdata;
            ADDR_TX_COMM:  tx_channel_comm_setting_r <= i_wdata;
            ADDR_TX_DATA: begin
               tx_channel_data_divider_r <= i_wdata;
               tx_hold_r                 <= i_wdata[8:0];
            end
            ADDR_RX_MODE:  rx_channel_mode_r         <= i_wdata;
            ADDR_RX_COMM:  rx_channel_comm_setting_r <= i_wdata;
            ADDR_RX_DATA:  rx_channel_data_divider_r <= {i_wdata[15:9], 9'h000};
            ADDR_IRQ_MASK: irq_mask_r                <= i_wdata[2:0];
            default: ;
         endcase
      end
   end

   // start strobes: one cycle, only while the channel is in uart mode
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_start_r <= 1'b0;
         rx_start_r <= 1'b0;
      end else begin
         tx_start_r <= i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_TX_START] &&
                       tx_cfg.proto == PROTO_UART;
         // rx start relies on software waiting after setting the enable
         rx_start_r <= i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_RX_START] &&
                       rx_cfg.proto == PROTO_UART;
      end
   end

   scu_channel #(.IS_RX(1'b0)) u_tx (
      .i_mclk          (i_mclk),
      .i_rstn          (i_rstn),
      .i_cfg           (tx_cfg),
      .i_dir_en        (tx_channel_comm_setting_r[COMM_TXE_BIT]),
      .i_ck0_en        (ck0_en),
      .i_ck1_en        (ck1_en),
      .i_sck           (i_sck),
      .i_start         (tx_start_r),
      .i_edge_start_en (1'b0),
      .i_rx_invert     (1'b0),
      .i_tx_data       (tx_hold_r),
      .i_rxd           (1'b1),
      .o_txd           (o_txd),
      .o_busy          (tx_busy),
      .o_buf_empty     (tx_empty),
      .o_done          (tx_done),
      .o_err           (tx_err),
      .o_rx_data       ()
   );

   scu_channel #(.IS_RX(1'b1)) u_rx (
      .i_mclk          (i_mclk),
      .i_rstn          (i_rstn),
      .i_cfg           (rx_cfg),
      .i_dir_en        (rx_channel_comm_setting_r[COMM_RXE_BIT]),
      .i_ck0_en        (ck0_en),
      .i_ck1_en        (ck1_en),
      .i_sck           (i_sck),
      .i_start         (rx_start_r),
      .i_edge_start_en (rx_channel_mode_r[MODE_STRIG_BIT]),
      .i_rx_invert     (rx_channel_mode_r[MODE_RXINV_BIT]),
      .i_tx_data       (9'h000),
      .i_rxd           (i_rxd),
      .o_txd           (),
      .o_busy          (),
      .o_buf_empty     (),
      .o_done          (rx_done),
      .o_err           (rx_err),
      .o_rx_data       (rx_data)
   );

   // tx event: frame end or rising buffer-empty, by the source bit
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn)
         tx_empty_q_r <= 1'b1;
      else
         tx_empty_q_r <= tx_empty;
   end
   assign tx_evt = tx_cfg.irq_source_select ? (tx_empty & ~tx_empty_q_r & tx_busy) :
                   tx_done;

   // sticky status: hardware set wins over write-one-to-clear
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (i_wr && i_addr == ADDR_IRQ_STAT)
         irq_stat_nxt = irq_stat_r & ~i_wdata[2:0];
      if (tx_evt)
         irq_stat_nxt[IRQ_TX_BIT] = 1'b1;
      if (rx_done)
         irq_stat_nxt[IRQ_RX_BIT] = 1'b1;
      // error only reaches status when the channel enables it
      if ((rx_err && rx_cfg.error_irq_enable) || (tx_err && tx_cfg.error_irq_enable))
         irq_stat_nxt[IRQ_ERR_BIT] = 1'b1;
   end
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn)
         irq_stat_r <= 3'h0;
      else
         irq_stat_r <= irq_stat_nxt;
   end
   assign o_irq       = |(irq_stat_r & irq_mask_r);
   assign o_uart_mode = (tx_cfg.proto == PROTO_UART);

   // read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn)
         o_rdata <= 16'h0000;
      else if (i_rd) begin
         unique case (i_addr)
            ADDR_TX_MODE:  o_rdata <= tx_channel_mode_r;
            ADDR_TX_COMM:  o_rdata <= tx_channel_comm_setting_r;
            ADDR_TX_DATA:  o_rdata <= tx_channel_data_divider_r;
            ADDR_RX_MODE:  o_rdata <= rx_channel_mode_r;
            ADDR_RX_COMM:  o_rdata <= rx_channel_comm_setting_r;
            ADDR_RX_DATA:  o_rdata <= {rx_channel_data_divider_r[15:9], rx_data};
            ADDR_CTRL:     o_rdata <= {15'h0000, tx_busy};
            ADDR_IRQ_STAT: o_rdata <= {13'h0000, irq_stat_r};
            ADDR_IRQ_MASK: o_rdata <= {13'h0000, irq_mask_r};
            default:       o_rdata <= 16'h0000;
         endcase
      end else
         o_rdata <= 16'h0000;
   end
endmodule

// File: test/scu_top_properties.sv
// assertion checker for the serial channel uart top, bound by port
`timescale 1ns/1ps
module scu_top_properties
   import scu_pkg::*;
(
   // clock, reset, register port and prescaler 0 select
   input wire logic        i_mclk,
   input wire logic        i_rstn,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [3:0]  i_presc0_sel,
   // observed outputs
   input wire logic [15:0] o_rdata,
   input wire logic        o_txd,
   input wire logic        o_irq,
   input wire logic        o_uart_mode
);
   logic [2:0] mask_r;
   logic       txe_r;
   logic       div1_r;
   logic       op0_r;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // shadows of writes; start bit length is only judged at a known divider
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         mask_r <= 3'h0;
         txe_r  <= 1'b0;
         div1_r <= 1'b0;
         op0_r  <= 1'b1;
      end else if (i_wr) begin
         if (i_addr == ADDR_IRQ_MASK) mask_r <= i_wdata[2:0];
         if (i_addr == ADDR_TX_COMM) txe_r <= i_wdata[COMM_TXE_BIT];
         if (i_addr == ADDR_TX_DATA) div1_r <= (i_wdata[15:9] == 7'h01);
         if (i_addr == ADDR_TX_MODE) op0_r <= (i_wdata[15:14] == 2'h0);
      end
   end
   sequence s_tx_start;
      i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_TX_START];
   endsequence
   sequence s_mask_wr;
      i_wr && i_addr == ADDR_IRQ_MASK;
   endsequence
   property p_start_bit;
      s_tx_start ##0 (txe_r && o_uart_mode && div1_r && op0_r && i_presc0_sel == 4'h0 && o_txd)
         |=> ##1 (!o_txd)[*4];
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit wrong");
   property p_refused;
      s_tx_start ##0 (!txe_r && o_txd) |=> o_txd[*8];
   endproperty
   a_refused: assert property (p_refused) else $error("start not refused");
   property p_rdata_idle;
      !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_unmapped;
      i_rd && i_addr > ADDR_IRQ_MASK |=> o_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mask_back;
      s_mask_wr ##2 (i_rd && i_addr == ADDR_IRQ_MASK) |=> o_rdata[2:0] == $past(i_wdata[2:0], 3);
   endproperty
   a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
   property p_irq_masked;
      mask_r == 3'h0 |-> !o_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
   property p_uart_mode;
      i_wr && i_addr == ADDR_TX_MODE |=> o_uart_mode == ($past(i_wdata[2:1]) == PROTO_UART);
   endproperty
   a_uart_mode: assert property (p_uart_mode) else $error("uart mode flag wrong");
   property p_reset_idle;
      $rose(i_rstn) |-> o_txd && !o_irq;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule
bind scu_top scu_top_properties u_props (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_presc0_sel(i_presc0_sel),
   .o_rdata(o_rdata), .o_txd(o_txd), .o_irq(o_irq), .o_uart_mode(o_uart_mode));

// File: test/scu_peer.sv
// remote uart peer: samples the transmit line, drives the receive line
`timescale 1ns/1ps
module scu_peer (
   // clock and serial lines
   input  wire logic i_mclk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   // line idles high between frames
   initial o_rxd = 1'b1;
   // wait for a start bit, then sample each later bit mid-cell
   task automatic get_bits(input int nb, input int bt, output logic [15:0] v);
      int k;
      v = 16'h0000;
      for (k = 0; k < 400 && i_txd !== 1'b0; k++) @(posedge i_mclk);
      repeat (bt / 2) @(posedge i_mclk);
      for (k = 0; k < nb; k++) begin
         repeat (bt) @(posedge i_mclk);
         v[k] = i_txd;
      end
   endtask
   // start bit, then nb bits in line order; caller supplies stop bits
   task automatic put_bits(input logic [15:0] v, input int nb, input int bt);
      int k;
      @(posedge i_mclk);
      o_rxd <= 1'b0;
      for (k = 0; k < nb; k++) begin
         repeat (bt) @(posedge i_mclk);
         o_rxd <= v[k];
      end
      repeat (bt) @(posedge i_mclk);
      o_rxd <= 1'b1;
   endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the serial channel uart top
`timescale 1ns/1ps
module testbench;
   import scu_pkg::*;
   logic        i_mclk, i_rstn, i_wr, i_rd, i_rxd, o_txd, o_irq, o_uart_mode;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata, o_rdata;
   int          n_mismatch = 0;
   int          comparisons = 0;
   scu_top DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_presc0_sel(4'h0), .i_presc1_sel(4'h1),
      .i_sck(1'b0), .i_rxd(i_rxd), .o_txd(o_txd), .o_irq(o_irq), .o_uart_mode(o_uart_mode));
   scu_peer peer (.i_mclk(i_mclk), .i_txd(o_txd), .o_rxd(i_rxd));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk_irq(input logic e);
      #1 chk("irq", {15'h0, e}, {15'h0, o_irq});
   endtask
   // expected line bits after the start bit; stop cells stay high
   function automatic logic [15:0] frame(input logic [8:0] d, input int n, input logic lsb,
         input logic [1:0] par);
      logic [15:0] f;
      logic        p;
      f = 16'hffff;
      p = ^(d & (9'h1ff >> (9 - n)));
      for (int k = 0; k < n; k++) f[k] = lsb ? d[k] : d[n - 1 - k];
      if (par != PAR_NONE) f[n] = (par == PAR_ZERO) ? 1'b0 : (par == PAR_EVEN) ? p : ~p;
      return f;
   endfunction
   task automatic send_chk(input logic [15:0] comm, input logic [8:0] d, input int n,
         input int bt, input logic mid_irq);
      logic [15:0] v;
      logic [15:0] e;
      int          nb;
      nb = n + int'(comm[9:8] != PAR_NONE) + int'(comm[5:4]);
      e = frame(d, n, comm[7], comm[9:8]) & (16'hffff >> (16 - nb));
      wr(ADDR_TX_COMM, comm);
      wr(ADDR_TX_DATA, {7'h01, d});
      fork
         peer.get_bits(nb, bt, v);
         wr(ADDR_CTRL, 16'h0001);
         begin
            repeat (5 * bt) @(posedge i_mclk);
            chk_irq(mid_irq);
         end
      join
      chk("tx frame", e, v);
   endtask
   task automatic t_reset;
      logic [3:0]  a [8];
      logic [15:0] e [8];
      logic [15:0] v;
      a = '{ADDR_TX_MODE, ADDR_TX_COMM, ADDR_TX_DATA, ADDR_RX_MODE, ADDR_RX_COMM,
            ADDR_RX_DATA, ADDR_IRQ_MASK, 4'h9};
      e = '{RST_MODE, RST_COMM, RST_DATA, RST_MODE, RST_COMM, RST_DATA, 16'h0, 16'h0};
      wr(4'h9, 16'hffff);
      for (int k = 0; k < 8; k++) begin
         rd(a[k], v);
         chk("reset value", e[k], v);
      end
      chk("uart mode", 16'h0001, {15'h0, o_uart_mode});
      chk_irq(1'b0);
   endtask
   task automatic t_tx_lsb;
      logic [15:0] v;
      wr(ADDR_IRQ_MASK, 16'h0007);
      send_chk(16'h8297, 9'h0a5, 8, 4, 1'b0);
      repeat (8) @(posedge i_mclk);
      chk_irq(1'b1);
      rd(ADDR_IRQ_STAT, v);
      chk("status", 16'h0001, v);
      wr(ADDR_IRQ_MASK, 16'h0000);
      chk_irq(1'b0);
      wr(ADDR_IRQ_MASK, 16'h0007);
      rd(ADDR_IRQ_MASK, v);
      chk("mask", 16'h0007, v);
      wr(ADDR_IRQ_STAT, 16'h0001);
      chk_irq(1'b0);
   endtask
   task automatic t_tx_msb;
      wr(ADDR_TX_MODE, 16'h8023);
      send_chk(16'h8326, 9'h05a, 7, 8, 1'b1);
      repeat (20) @(posedge i_mclk);
      wr(ADDR_IRQ_STAT, 16'h0007);
      wr(ADDR_TX_MODE, 16'h0022);
   endtask
   // csi or i2c mode, or transmit disabled: a start must leave the line idle
   task automatic t_refuse;
      logic [15:0] m [3];
      logic [15:0] c [3];
      logic [15:0] v;
      m = '{16'h0024, 16'h0020, 16'h0022};
      c = '{16'h8297, 16'h8297, 16'h0097};
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_TX_MODE, m[k]);
         wr(ADDR_TX_COMM, c[k]);
         #1 chk("uart mode", {15'h0, k == 2}, {15'h0, o_uart_mode});
         wr(ADDR_CTRL, 16'h0001);
         v = 16'h0001;
         repeat (20) @(posedge i_mclk) v = v & {15'h0, o_txd};
         chk("idle line", 16'h0001, v);
         rd(ADDR_CTRL, v);
         chk("busy", 16'h0000, v & 16'h0001);
      end
   endtask
   task automatic t_rx;
      logic [15:0] f;
      logic [15:0] v;
      wr(ADDR_RX_MODE, 16'h0122);
      wr(ADDR_RX_COMM, 16'h4697);
      wr(ADDR_RX_DATA, 16'h0200);
      repeat (RX_SETTLE_CYC) @(posedge i_mclk);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wr(ADDR_RX_COMM, 16'h4297);
         wr(ADDR_CTRL, 16'h0002);
         f = frame(9'h03c, 8, 1'b1, PAR_EVEN);
         if (k > 0) f[8] = ~f[8];
         peer.put_bits(f, 10, 4);
         repeat (8) @(posedge i_mclk);
         rd(ADDR_RX_DATA, v);
         if (k == 0) chk("rx data", 16'h003c, v & 16'h01ff);
         rd(ADDR_IRQ_STAT, v);
         chk("error status", (k == 1) ? 16'h0004 : 16'h0000, v & 16'h0004);
         if (k == 1) chk_irq(1'b1);
         wr(ADDR_IRQ_STAT, 16'h0007);
      end
   endtask
   initial begin
      i_rstn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      t_reset;
      t_tx_lsb;
      t_tx_msb;
      t_refuse;
      t_rx;
      end_of_test;
   end
   // watchdog well past the few hundred cycles the scenarios need
   initial begin
      #500000;
      n_mismatch++;
      end_of_test;
   end
endmodule
